//--- inc/hdf_params.svh
`ifndef HDF_PARAMS_SVH
`define HDF_PARAMS_SVH
// node type value is arbitrary
`define HDF_NODE_TYPE    3'h2
`define HDF_FN_CLEAR     4'h0
`define HDF_FN_IFIELD    4'h1
`define HDF_FN_ANSWER    4'h2
`define HDF_FN_DISCON    4'h3
`define HDF_FN_PARITY    4'h4
`define HDF_FN_UNUSED    4'h5
`define HDF_FN_PKTRD     4'h6
`define HDF_FN_STATUS    4'h7
`define HDF_FN_LOOP_IN   4'h8
`define HDF_FN_LOOP_OUT  4'h9
`define HDF_FN_DEVADDR   4'hA
`define HDF_FN_READY     4'hB
`define HDF_FN_RD_LO     4'hC
`define HDF_FN_RD_HI     4'hD
`define HDF_FN_WR_LO     4'hE
`define HDF_FN_WR_HI     4'hF
`define HDF_BLK_WORDS    10'h040
`define HDF_REJECT_CLKS  3'h4
`define HDF_PKT_EMPTY    16'h8000
`define HDF_MODE_BIT     14
`define HDF_REJECT_BIT   15
`define HDF_PS_HIP_BIT   26
`define HDF_PS_HBYTE_LO  24
`define HDF_PS_BUF_BIT   23
`define HDF_PS_BBYTE_LO  20
`define HDF_GS_PKTCNT_LO 6
`define HDF_GS_LOST      16
`define HDF_GS_SRCDISC   17
`define HDF_GS_HIPPAR    18
`define HDF_GS_BUFPAR    19
`define HDF_GS_MODE64    20
`define HDF_GS_INTFLAG   21
`define HDF_GS_ICB       22
`define HDF_ZERO32       32'h0000_0000
`endif

//--- inc/hdf_pkg.sv
package hdf_pkg;
	typedef enum logic [2:0] {IDLE, COLLECT, RESP, WAIT_WORD, RX_WAIT, RX, TX, TX_ACK} hdf_state_t;
	typedef struct packed {
		logic [11:0] addr;
		logic        load;
		logic        parcelWr;
		logic        parcelRd;
		logic        wordRd;
		logic        wordWr;
		logic        upper;
		logic [31:0] wdata;
	} hdf_buf_req_t;
endpackage

//--- rtl/hdf_pkt_queue.sv
`timescale 1ns/1ns
`default_nettype none
module hdf_pkt_queue #(
	parameter int W     = 16,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         clkEn,
	// control
	input  wire logic         clear,
	input  wire logic         push,
	input  wire logic [W-1:0] pushData,
	input  wire logic         pop,
	// state
	output logic      [W-1:0] head,
	output logic      [5:0]   count
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic          doPush;
	logic          doPop;

	initial begin
		if (DEPTH < 2 || DEPTH > 32 || (1 << AW) != DEPTH)
			$error("hdf_pkt_queue: DEPTH must be a power of two from 2 to 32");
	end

	assign doPop  = pop && count != 6'h00;
	// a full queue drops new entries rather than overwrite the oldest
	assign doPush = push && (count != 6'(DEPTH) || doPop);
	assign head   = mem[rdPtr];

	always_ff @(posedge clock) begin
		if (clkEn && doPush)
			mem[wrPtr] <= pushData;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= 6'h00;
		end else if (clkEn) begin
			if (clear) begin
				wrPtr <= '0;
				rdPtr <= '0;
				count <= 6'h00;
			end else begin
				if (doPush)
					wrPtr <= wrPtr + 1'b1;
				if (doPop)
					rdPtr <= rdPtr + 1'b1;
				count <= count + 6'(doPush) - 6'(doPop);
			end
		end
	end
endmodule // hdf_pkt_queue
`default_nettype wire

//--- rtl/hdf_function_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "hdf_params.svh"
module hdf_function_decoder #(
	parameter int QDEPTH = 32
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 clkEn,
	// channel loop in
	input  wire logic [3:0]           nodeAddr,
	input  wire logic                 fnPulse,
	input  wire logic                 callPulse,
	input  wire logic                 dataPulseIn,
	input  wire logic                 inValid,
	input  wire logic [15:0]          inParcel,
	// channel loop out
	output logic                      respValid,
	output logic [15:0]               respParcel,
	output logic                      dataPulseOut,
	output logic                      outValid,
	output logic [15:0]               outParcel,
	// link side
	input  wire logic                 loopback,
	input  wire logic                 request,
	input  wire logic                 linkClkFall,
	input  wire logic [31:0]          ifieldIn,
	input  wire logic                 burstErr,
	input  wire logic [3:0]           linkParLanes,
	input  wire logic                 wide64In,
	output logic                      connectOut,
	output logic                      wide64Out,
	output logic                      readyAddValid,
	output logic [5:0]                readyAddCount,
	output logic [12:0]               devBufAddr,
	output logic                      intFlag,
	// buffer stack
	output hdf_pkg::hdf_buf_req_t     bufReq,
	input  wire logic                 bufRdValid,
	input  wire logic [31:0]          bufRdData,
	input  wire logic [7:0]           bufParLanes,
	// packet file entries
	input  wire logic                 pktPush,
	input  wire logic [15:0]          pktEntry
);
	hdf_pkg::hdf_state_t state;
	hdf_pkg::hdf_state_t retState;
	logic [15:0] p0, p1, p2, respLo;
	logic [1:0]  pIdx;
	logic [9:0]  xferLen, lenNext;
	logic [7:0]  blkCnt, blkLoad;
	logic [11:0] loopAddr;
	logic        firstBlk, txWait;
	logic        connect, rejecting, reqD;
	logic [2:0]  rejCnt;
	logic [31:0] ifield, parWord, genStatus;
	logic        lostFn, srcDisc, gsLinkPar, gsBufPar, mode64, callEnabled;
	logic [15:0] callResp;
	logic [15:0] pktHead;
	logic [5:0]  pktCount;
	logic        reqEff, reqFall, reqRise, linkParEvt, bufParEvt;
	logic [1:0]  linkByte;
	logic [2:0]  bufByte;
	logic        fnExec, canReq, lostSet, clrCtl, rdPar, rdGs, popQ, connSet, drop3;
	logic        accCall, acc12, acc13;
	logic [3:0]  code;

	initial begin
		if (QDEPTH < 2 || QDEPTH > 32)
			$error("hdf_function_decoder: QDEPTH must be 2 to 32");
	end

	hdf_pkt_queue #(.W(16), .DEPTH(QDEPTH)) pktQueue (
		.clock    (clock),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.clear    (clrCtl),
		.push     (pktPush),
		.pushData (pktEntry),
		.pop      (popQ),
		.head     (pktHead),
		.count    (pktCount)
	);

	// external inputs are dead while looped back
	assign reqEff     = request && !loopback;
	assign reqFall    = reqD && !reqEff;
	assign reqRise    = !reqD && reqEff;
	assign linkParEvt = |linkParLanes && !loopback;
	assign bufParEvt  = state == hdf_pkg::TX && txWait && bufRdValid && |bufParLanes;

	always_comb begin
		linkByte = 2'h0;
		bufByte  = 3'h0;
		for (int i = 3; i >= 0; i--) begin
			if (linkParLanes[i])
				linkByte = 2'(i);
		end
		for (int i = 0; i < 8; i++) begin
			if (bufParLanes[i])
				bufByte = 3'(7 - i);
		end
	end

	assign code   = p0[3:0];
	assign fnExec = state == hdf_pkg::COLLECT && inValid && pIdx == 2'h2;
	assign canReq = reqEff && !connect;
	// a lost code only raises its flag and answers zero
	assign lostSet = fnExec && (((code == `HDF_FN_IFIELD || code == `HDF_FN_ANSWER) && !canReq)
		|| ((code == `HDF_FN_DISCON || code == `HDF_FN_READY) && !connect));
	assign clrCtl  = fnExec && code == `HDF_FN_CLEAR;
	assign rdPar   = fnExec && code == `HDF_FN_PARITY;
	assign rdGs    = fnExec && code == `HDF_FN_STATUS;
	assign popQ    = fnExec && code == `HDF_FN_PKTRD;
	assign connSet = fnExec && code == `HDF_FN_ANSWER && canReq;
	assign drop3   = fnExec && code == `HDF_FN_DISCON && connect;
	assign acc13   = fnExec && code == `HDF_FN_READY && connect;
	assign acc12   = fnExec && code == `HDF_FN_DEVADDR;
	assign accCall = connSet || drop3 || rdGs || acc13;

	// full block whenever 64 or more words remain
	assign blkLoad = (xferLen >= `HDF_BLK_WORDS) ? 8'h00 : {xferLen[5:0], 2'b00};
	assign lenNext = (xferLen >= `HDF_BLK_WORDS) ? xferLen - `HDF_BLK_WORDS : 10'h000;

	always_comb begin
		genStatus = `HDF_ZERO32;
		genStatus[`HDF_GS_PKTCNT_LO +: 6] = pktCount;
		genStatus[`HDF_GS_LOST]    = lostFn;
		genStatus[`HDF_GS_SRCDISC] = srcDisc;
		genStatus[`HDF_GS_HIPPAR]  = gsLinkPar;
		genStatus[`HDF_GS_BUFPAR]  = gsBufPar;
		genStatus[`HDF_GS_MODE64]  = mode64;
		genStatus[`HDF_GS_INTFLAG] = intFlag;
		genStatus[`HDF_GS_ICB]     = wide64In && !loopback;
	end

	// sequencer; new codes are taken only from idle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state        <= hdf_pkg::IDLE;
			retState     <= hdf_pkg::IDLE;
			p0           <= 16'h0000;
			p1           <= 16'h0000;
			p2           <= 16'h0000;
			pIdx         <= 2'h0;
			respLo       <= 16'h0000;
			respValid    <= 1'b0;
			respParcel   <= 16'h0000;
			dataPulseOut <= 1'b0;
			outValid     <= 1'b0;
			outParcel    <= 16'h0000;
			bufReq       <= '0;
			xferLen      <= 10'h000;
			blkCnt       <= 8'h00;
			loopAddr     <= 12'h000;
			firstBlk     <= 1'b0;
			txWait       <= 1'b0;
		end else if (clkEn) begin
			respValid    <= 1'b0;
			dataPulseOut <= 1'b0;
			outValid     <= 1'b0;
			bufReq       <= '0;
			case (state)
			hdf_pkg::IDLE: begin
				if (fnPulse && inParcel[15:9] == {`HDF_NODE_TYPE, nodeAddr}) begin
					p0    <= inParcel;
					pIdx  <= 2'h0;
					state <= hdf_pkg::COLLECT;
				end else if (callPulse && callEnabled && intFlag) begin
					respValid  <= 1'b1;
					respParcel <= 16'h0000;
					respLo     <= callResp;
					retState   <= hdf_pkg::IDLE;
					state      <= hdf_pkg::RESP;
				end
			end
			hdf_pkg::COLLECT: begin
				if (inValid) begin
					pIdx <= pIdx + 2'h1;
					if (pIdx == 2'h0)
						p1 <= inParcel;
					if (pIdx == 2'h1)
						p2 <= inParcel;
				end
				if (fnExec) begin
					respValid  <= 1'b1;
					respParcel <= 16'h0000;
					respLo     <= 16'h0000;
					retState   <= hdf_pkg::IDLE;
					state      <= hdf_pkg::RESP;
					case (code)
					`HDF_FN_IFIELD: begin
						if (canReq) begin
							respParcel <= ifield[31:16];
							respLo     <= ifield[15:0];
						end
					end
					`HDF_FN_PARITY: begin
						respParcel <= parWord[31:16];
						respLo     <= parWord[15:0];
					end
					`HDF_FN_PKTRD:
						respLo <= (pktCount == 6'h00) ? `HDF_PKT_EMPTY : pktHead;
					`HDF_FN_STATUS: begin
						respParcel <= genStatus[31:16];
						respLo     <= genStatus[15:0];
					end
					`HDF_FN_UNUSED: begin
						respValid <= 1'b0;
						state     <= hdf_pkg::IDLE;
					end
					`HDF_FN_LOOP_IN: begin
						loopAddr <= p1[11:0];
						xferLen  <= inParcel[9:0];
						firstBlk <= 1'b1;
						if (inParcel[9:0] != 10'h000)
							retState <= hdf_pkg::RX_WAIT;
					end
					`HDF_FN_LOOP_OUT: begin
						xferLen <= inParcel[9:0];
						if (inParcel[9:0] != 10'h000) begin
							respValid     <= 1'b0;
							bufReq.load   <= 1'b1;
							bufReq.addr   <= p1[11:0];
							dataPulseOut  <= 1'b1;
							blkCnt        <= (inParcel[9:0] >= `HDF_BLK_WORDS) ? 8'h00
								: {inParcel[5:0], 2'b00};
							txWait        <= 1'b0;
							state         <= hdf_pkg::TX;
						end
					end
					`HDF_FN_RD_LO, `HDF_FN_RD_HI: begin
						respValid     <= 1'b0;
						bufReq.wordRd <= 1'b1;
						bufReq.addr   <= p1[11:0];
						bufReq.upper  <= code[0];
						state         <= hdf_pkg::WAIT_WORD;
					end
					`HDF_FN_WR_LO, `HDF_FN_WR_HI: begin
						bufReq.wordWr <= 1'b1;
						bufReq.addr   <= p1[11:0];
						bufReq.upper  <= code[0];
						bufReq.wdata  <= {p2, inParcel};
					end
					default: begin
					end
					endcase
				end
			end
			hdf_pkg::RESP: begin
				respValid  <= 1'b1;
				respParcel <= respLo;
				state      <= retState;
			end
			hdf_pkg::WAIT_WORD: begin
				if (bufRdValid) begin
					respValid  <= 1'b1;
					respParcel <= bufRdData[31:16];
					respLo     <= bufRdData[15:0];
					retState   <= hdf_pkg::IDLE;
					state      <= hdf_pkg::RESP;
				end
			end
			hdf_pkg::RX_WAIT: begin
				if (callPulse)
					state <= hdf_pkg::IDLE;
				else if (dataPulseIn) begin
					bufReq.load <= firstBlk;
					bufReq.addr <= loopAddr;
					firstBlk    <= 1'b0;
					blkCnt      <= blkLoad;
					state       <= hdf_pkg::RX;
				end
			end
			hdf_pkg::RX: begin
				// data pulses arriving mid-block are ignored here
				if (callPulse)
					state <= hdf_pkg::IDLE;
				else if (inValid) begin
					bufReq.parcelWr <= 1'b1;
					bufReq.wdata    <= {16'h0000, inParcel};
					blkCnt          <= blkCnt - 8'h01;
					if (blkCnt == 8'h01) begin
						dataPulseOut <= 1'b1;
						xferLen      <= lenNext;
						state        <= (lenNext == 10'h000) ? hdf_pkg::IDLE : hdf_pkg::RX_WAIT;
					end
				end
			end
			hdf_pkg::TX: begin
				// one parcel in flight at a time keeps the buffer handshake trivial
				if (callPulse) begin
					respValid  <= 1'b1;
					respParcel <= 16'h0000;
					respLo     <= 16'h0000;
					retState   <= hdf_pkg::IDLE;
					state      <= hdf_pkg::RESP;
				end else if (!txWait) begin
					bufReq.parcelRd <= 1'b1;
					txWait          <= 1'b1;
				end else if (bufRdValid) begin
					outValid  <= 1'b1;
					outParcel <= bufRdData[15:0];
					txWait    <= 1'b0;
					blkCnt    <= blkCnt - 8'h01;
					if (blkCnt == 8'h01) begin
						xferLen <= lenNext;
						state   <= hdf_pkg::TX_ACK;
					end
				end
			end
			hdf_pkg::TX_ACK: begin
				if (callPulse || (dataPulseIn && xferLen == 10'h000)) begin
					respValid  <= 1'b1;
					respParcel <= 16'h0000;
					respLo     <= 16'h0000;
					retState   <= hdf_pkg::IDLE;
					state      <= hdf_pkg::RESP;
				end else if (dataPulseIn) begin
					blkCnt       <= blkLoad;
					dataPulseOut <= 1'b1;
					txWait       <= 1'b0;
					state        <= hdf_pkg::TX;
				end
			end
			default:
				state <= hdf_pkg::IDLE;
			endcase
		end
	end

	// connection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			connect    <= 1'b0;
			rejecting  <= 1'b0;
			rejCnt     <= 3'h0;
			reqD       <= 1'b0;
			ifield     <= `HDF_ZERO32;
			connectOut <= 1'b0;
		end else if (clkEn) begin
			reqD       <= reqEff;
			connectOut <= connect && !loopback;
			if (reqRise)
				ifield <= ifieldIn;
			if (clrCtl) begin
				connect   <= 1'b0;
				rejecting <= 1'b0;
			end else if (connSet) begin
				connect   <= 1'b1;
				rejecting <= p2[`HDF_REJECT_BIT];
				rejCnt    <= `HDF_REJECT_CLKS;
			end else if (reqFall || (burstErr && !loopback) || drop3) begin
				connect   <= 1'b0;
				rejecting <= 1'b0;
			end else if (rejecting && linkClkFall && !loopback) begin
				rejCnt <= rejCnt - 3'h1;
				if (rejCnt == 3'h1) begin
					connect   <= 1'b0;
					rejecting <= 1'b0;
				end
			end
		end
	end

	// status and parity flags: a new event beats a clear in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lostFn      <= 1'b0;
			srcDisc     <= 1'b0;
			gsLinkPar   <= 1'b0;
			gsBufPar    <= 1'b0;
			intFlag     <= 1'b0;
			mode64      <= 1'b0;
			callEnabled <= 1'b0;
			callResp    <= 16'h0000;
			parWord     <= `HDF_ZERO32;
			wide64Out   <= 1'b0;
		end else if (clkEn) begin
			lostFn    <= lostSet || (lostFn && !rdGs && !clrCtl);
			srcDisc   <= reqFall || (srcDisc && !rdGs && !clrCtl);
			gsLinkPar <= linkParEvt || (gsLinkPar && !rdGs && !rdPar && !clrCtl);
			gsBufPar  <= bufParEvt || (gsBufPar && !rdGs && !rdPar && !clrCtl);
			// flag sets even while calls are still disabled
			intFlag   <= reqFall || reqRise || (intFlag && !rdGs && !clrCtl);
			wide64Out <= mode64 && !loopback;
			if (clrCtl) begin
				mode64      <= p2[`HDF_MODE_BIT];
				callEnabled <= 1'b0;
			end else if (accCall) begin
				callEnabled <= 1'b1;
				callResp    <= p1;
			end
			if (linkParEvt) begin
				parWord[`HDF_PS_HIP_BIT]        <= 1'b1;
				parWord[`HDF_PS_HBYTE_LO +: 2]  <= linkByte;
			end else if (rdPar || clrCtl) begin
				parWord[`HDF_PS_HIP_BIT]        <= 1'b0;
				parWord[`HDF_PS_HBYTE_LO +: 2]  <= 2'h0;
			end
			if (bufParEvt) begin
				parWord[`HDF_PS_BUF_BIT]        <= 1'b1;
				parWord[`HDF_PS_BBYTE_LO +: 3]  <= bufByte;
			end else if (rdPar || clrCtl) begin
				parWord[`HDF_PS_BUF_BIT]        <= 1'b0;
				parWord[`HDF_PS_BBYTE_LO +: 3]  <= 3'h0;
			end
		end
	end

	// ready credit and device address
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			readyAddValid <= 1'b0;
			readyAddCount <= 6'h00;
			devBufAddr    <= 13'h0000;
		end else if (clkEn) begin
			readyAddValid <= acc13 && !loopback;
			if (acc13)
				readyAddCount <= inParcel[5:0];
			if (clrCtl || connSet)
				devBufAddr <= 13'h0000;
			else if (acc12)
				devBufAddr <= p1[12:0];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_zero_answer;
		respValid && respParcel == 16'h0000 ##1 respValid && respParcel == 16'h0000;
	endsequence

	a_unused_silent: assert property (clkEn && fnExec && code == `HDF_FN_UNUSED |=> !respValid && state == hdf_pkg::IDLE) else $error("unused code answered");
	a_clear_answer: assert property (clkEn && clrCtl ##1 clkEn |-> s_zero_answer) else $error("clear did not answer zero");
	a_clear_mode: assert property (clkEn && clrCtl |=> mode64 == $past(p2[14]) && !connect) else $error("clear mode wrong");
	a_loop_quiet: assert property (loopback && $past(loopback) |-> !connectOut && !wide64Out && !readyAddValid) else $error("output active in loopback");
	a_ifield_lost: assert property (clkEn && fnExec && code == `HDF_FN_IFIELD && !canReq ##1 clkEn |-> s_zero_answer and ##1 lostFn) else $error("lost i-field wrong");
	a_discon_drop: assert property (clkEn && drop3 |=> !connect) else $error("connect not dropped");
	a_req_drop: assert property (clkEn && reqFall |=> !connect && intFlag && srcDisc) else $error("request fall not handled");
	a_par_clear: assert property (clkEn && rdPar && !linkParEvt && !bufParEvt |=> parWord == 32'h0000_0000 && !gsLinkPar) else $error("parity word not cleared");
	a_pkt_empty: assert property (clkEn && popQ && pktCount == 6'h00 ##1 clkEn |-> ##1 respValid && respParcel == 16'h8000) else $error("empty value wrong");
	a_blk_pulse: assert property (clkEn && state == hdf_pkg::RX && inValid && !callPulse && blkCnt == 8'h01 |=> dataPulseOut) else $error("block end pulse missing");
	a_node_match: assert property (clkEn && state == hdf_pkg::IDLE && fnPulse && inParcel[15:9] != {`HDF_NODE_TYPE, nodeAddr} && !callPulse |=> state == hdf_pkg::IDLE) else $error("foreign code taken");
endmodule // hdf_function_decoder
`default_nettype wire

//--- verif/hdf_buf_model.sv
`timescale 1ns/1ns
`default_nettype none
module hdf_buf_model (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	// request from decoder
	input  wire hdf_pkg::hdf_buf_req_t bufReq,
	// read answer
	output logic                       bufRdValid,
	output logic [31:0]                bufRdData,
	output logic [7:0]                 bufParLanes
);
	// data follows the address so a wrong address shows; idle data never holds
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bufRdValid <= 1'b0;
			bufRdData  <= 32'h0000_0000;
		end else begin
			bufRdValid <= bufReq.wordRd | bufReq.parcelRd;
			if (bufReq.wordRd | bufReq.parcelRd) begin
				bufRdData <= {4'hA, bufReq.addr, 4'h5, bufReq.addr};
			end else begin
				bufRdData <= ~bufRdData;
			end
		end
	end
	assign bufParLanes = 8'h00;
endmodule // hdf_buf_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "hdf_params.svh"
module tb;
	logic                  clock = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  fnPulse = 1'b0;
	logic                  callPulse = 1'b0;
	logic                  dataPulseIn = 1'b0;
	logic                  inValid = 1'b0;
	logic                  request = 1'b0;
	logic                  loopback = 1'b0;
	logic [3:0]            outCnt = 4'h0;
	logic                  linkClkFall = 1'b0;
	logic                  pktPush = 1'b0;
	logic [3:0]            linkParLanes = 4'h0;
	logic [15:0]           inParcel = 16'h0000;
	logic [15:0]           pktEntry = 16'h0000;
	logic [31:0]           ifieldIn = 32'hC0DE_0101;
	logic [31:0]           wrSeen = 32'h0000_0000;
	logic [15:0]           r1, r2, respParcel, outParcel;
	logic [31:0]           w, bufRdData;
	logic                  respValid, dataPulseOut, outValid, connectOut, wide64Out;
	logic                  readyAddValid, intFlag, bufRdValid, got;
	logic [7:0]            bufParLanes;
	logic [5:0]            readyAddCount;
	logic [12:0]           devBufAddr;
	hdf_pkg::hdf_buf_req_t bufReq;
	int                    error_cnt = 0;
	int                    check_count = 0;
	always #20 clock = ~clock;
	always @(posedge clock) linkClkFall <= ~linkClkFall;
	always @(posedge clock) if (bufReq.wordWr === 1'b1) wrSeen <= bufReq.wdata;
	// loop receiver: acknowledge each four-parcel block with one data pulse
	always @(posedge clock) begin
		dataPulseIn <= 1'b0;
		if (outValid === 1'b1) begin
			outCnt <= outCnt + 4'h1;
			if (outCnt[1:0] == 2'h3)
				dataPulseIn <= 1'b1;
		end
	end
	hdf_function_decoder hdf_function_decoder_inst (.*, .clkEn(1'b1), .nodeAddr(4'h3),
		.wide64In(1'b0), .burstErr(1'b0));
	hdf_buf_model hdf_buf_model_inst (.*);
	task conclude;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one whole function: id parcel, three parcels, then the two-cycle answer
	task fn(input logic [3:0] c, input logic [15:0] p1, p2, p3);
		@(posedge clock) fnPulse <= 1'b1;
		inParcel <= {`HDF_NODE_TYPE, 4'h3, 5'h00, c};
		@(posedge clock) fnPulse <= 1'b0;
		inValid <= 1'b1;
		inParcel <= p1;
		@(posedge clock) inParcel <= p2;
		@(posedge clock) inParcel <= p3;
		@(posedge clock) inValid <= 1'b0;
		got = 1'b0;
		for (int i = 0; i < 40 && !got; i++) begin
			@(posedge clock);
			got = (respValid === 1'b1);
		end
		r1 = respParcel;
		@(posedge clock);
		r2 = respParcel;
		w = {r1, r2};
	endtask
	initial begin
		#2000000;
		error_cnt++;
		conclude;
	end
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		fn(`HDF_FN_CLEAR, 16'h0000, 16'h4000, 16'h0000);
		chk(w, `HDF_ZERO32);
		chk(wide64Out, 1'b1);
		fn(`HDF_FN_IFIELD, 16'h0000, 16'h0000, 16'h0000);
		chk(w, `HDF_ZERO32);
		fn(`HDF_FN_STATUS, 16'h0000, 16'h0000, 16'h0000);
		chk(w[`HDF_GS_LOST], 1'b1);
		fn(`HDF_FN_STATUS, 16'h0000, 16'h0000, 16'h0000);
		chk(w[`HDF_GS_LOST], 1'b0);
		$display("test clear and status done");
		@(posedge clock) pktPush <= 1'b1;
		pktEntry <= 16'h0123;
		@(posedge clock) pktPush <= 1'b0;
		fn(`HDF_FN_PKTRD, 16'h0000, 16'h0000, 16'h0000);
		chk(w, 32'h0000_0123);
		fn(`HDF_FN_PKTRD, 16'h0000, 16'h0000, 16'h0000);
		chk(w, {16'h0000, `HDF_PKT_EMPTY});
		@(posedge clock) linkParLanes <= 4'h4;
		@(posedge clock) linkParLanes <= 4'h0;
		fn(`HDF_FN_PARITY, 16'h0000, 16'h0000, 16'h0000);
		chk(w, 32'h0600_0000);
		fn(`HDF_FN_PARITY, 16'h0000, 16'h0000, 16'h0000);
		chk(w, `HDF_ZERO32);
		$display("test packet and parity done");
		@(posedge clock) request <= 1'b1;
		repeat (4) @(posedge clock);
		fn(`HDF_FN_IFIELD, 16'h0000, 16'h0000, 16'h0000);
		chk(w, 32'hC0DE_0101);
		fn(`HDF_FN_ANSWER, 16'h0000, 16'h0000, 16'h0000);
		repeat (3) @(posedge clock);
		chk(connectOut, 1'b1);
		fn(`HDF_FN_DISCON, 16'h0000, 16'h0000, 16'h0000);
		repeat (3) @(posedge clock);
		chk(connectOut, 1'b0);
		@(posedge clock) loopback <= 1'b1;
		repeat (3) @(posedge clock);
		chk(wide64Out, 1'b0);
		fn(`HDF_FN_IFIELD, 16'h0000, 16'h0000, 16'h0000);
		chk(w, `HDF_ZERO32);
		@(posedge clock) loopback <= 1'b0;
		repeat (3) @(posedge clock);
		chk(wide64Out, 1'b1);
		$display("test connect done");
		fn(`HDF_FN_WR_LO, 16'h0012, 16'h1234, 16'h5678);
		chk(wrSeen, 32'h1234_5678);
		fn(`HDF_FN_RD_LO, 16'h0012, 16'h0000, 16'h0000);
		chk(w, 32'hA012_5012);
		fn(`HDF_FN_LOOP_IN, 16'h0012, 16'h0000, 16'h0000);
		chk(w, `HDF_ZERO32);
		fn(`HDF_FN_LOOP_OUT, 16'h0012, 16'h0000, 16'h0000);
		chk(w, `HDF_ZERO32);
		fn(`HDF_FN_LOOP_OUT, 16'h0012, 16'h0000, 16'h0001);
		chk(w, `HDF_ZERO32);
		chk(outCnt, 4'h4);
		chk(outParcel, 16'h5000);
		// left for last: an unused code gets no answer, so fn waits out its 40-cycle limit
		fn(`HDF_FN_UNUSED, 16'h0000, 16'h0000, 16'h0000);
		chk(got, 1'b0);
		$display("test buffer and unused done");
		conclude;
	end
endmodule // tb
`default_nettype wire
